// File: inc/ptc_defs.vh
// Register map, field positions, codes and reset values of the periodic timer block
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH
// ==========================================================
// Per-timer register offsets, timer base = index * 8
`define PTC_OFS_CTL0 3'h0
`define PTC_OFS_CTL1 3'h1
`define PTC_OFS_CNTL 3'h2
`define PTC_OFS_CNTH 3'h3
`define PTC_OFS_CMPAL 3'h4
`define PTC_OFS_CMPAH 3'h5
`define PTC_OFS_CMPPL 3'h6
`define PTC_OFS_CMPPH 3'h7
// ==========================================================
// Shared registers
`define PTC_OFS_ROUTE 8'h20
`define PTC_OFS_STAT 8'h21
`define PTC_OFS_MASK 8'h22
// ==========================================================
// First control register fields
`define PTC_C0_RUN 7
`define PTC_C0_PAU 6
`define PTC_C0_CKS_HI 2
`define PTC_C0_CKS_LO 0
// Second control register fields
`define PTC_C1_MODE_HI 7
`define PTC_C1_MODE_LO 6
`define PTC_C1_IO_HI 5
`define PTC_C1_IO_LO 4
`define PTC_C1_POL 3
`define PTC_C1_EDGE 2
`define PTC_C1_CCLR 0
// ==========================================================
// Clock source codes
`define PTC_CKS_SYS4 3'h0
`define PTC_CKS_SYS 3'h1
`define PTC_CKS_H16 3'h2
`define PTC_CKS_H64 3'h3
`define PTC_CKS_SUB0 3'h4
`define PTC_CKS_SUB1 3'h5
// Operating modes
`define PTC_MODE_CMP 2'h0
`define PTC_MODE_TMR 2'h1
`define PTC_MODE_PWM 2'h2
`define PTC_MODE_SPO 2'h3
// Compare match output actions
`define PTC_IO_LOW 2'h1
`define PTC_IO_HIGH 2'h2
`define PTC_IO_TGL 2'h3
// ==========================================================
// Reset values and counter widths
`define PTC_RST_BYTE 8'h00
`define PTC_WIDE 16
`define PTC_NARROW 10
`endif

// File: hw/ptc_sync.v
// Three-stage synchroniser with agreement filter for one pin input
module ptc_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Pin side
  input wire asyncIn,
  // Clock domain side
  output wire syncOut
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg q_r;

  // ==========================================================
  // Stages; level taken only once stage two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      s1_r <= asyncIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end

  assign syncOut = q_r;
endmodule // ptc_sync

// File: hw/ptc_timer.v
// One periodic timer: count-up counter, two comparators, output control
`include "ptc_defs.vh"
module ptc_timer #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire tick,
  input wire run,
  input wire pause,
  input wire [1:0] mode,
  input wire [1:0] ioSel,
  input wire pol,
  input wire cclr,
  input wire trig,
  // Compare values
  input wire [15:0] cmpA,
  input wire [15:0] cmpP,
  // Results
  output wire [15:0] cntOut,
  output wire matchA,
  output wire matchP,
  output wire lvl
);
  reg [WIDTH-1:0] cnt_r;
  reg [WIDTH-1:0] cnt_nxt;
  reg runD_r;
  reg spoOn_r;
  reg out_r;
  reg out_nxt;

  // ==========================================================
  // Count qualification and comparators
  wire runRise = run & ~runD_r;
  wire gate = (mode != `PTC_MODE_SPO) | spoOn_r;
  wire active = run & ~pause & tick & gate;
  assign matchA = active & (cnt_r == cmpA[WIDTH-1:0]);
  assign matchP = active & (cnt_r == cmpP[WIDTH-1:0]);
  wire ovf = active & (&cnt_r);
  wire clrHit = cclr ? matchA : matchP;
  wire spoEnd = (mode == `PTC_MODE_SPO) & matchA;

  // Next counter value
  always @* begin
    cnt_nxt = cnt_r;
    if (runRise) begin
      cnt_nxt = {WIDTH{1'b0}};
    end else if (active) begin
      if (clrHit | ovf | spoEnd) begin
        cnt_nxt = {WIDTH{1'b0}};
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Next output level per mode
  always @* begin
    out_nxt = out_r;
    case (mode)
      `PTC_MODE_CMP: begin
        if (matchA) begin
          case (ioSel)
            `PTC_IO_LOW: out_nxt = 1'b0;
            `PTC_IO_HIGH: out_nxt = 1'b1;
            `PTC_IO_TGL: out_nxt = ~out_r;
            default: out_nxt = out_r;
          endcase
        end
      end
      `PTC_MODE_TMR: out_nxt = 1'b0;
      `PTC_MODE_PWM: out_nxt = (cnt_r < cmpA[WIDTH-1:0]);
      `PTC_MODE_SPO: out_nxt = spoOn_r;
      default: out_nxt = out_r;
    endcase
    if (!run) begin
      out_nxt = 1'b0;
    end
  end

  // ==========================================================
  // State registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {WIDTH{1'b0}};
      runD_r <= 1'b0;
      spoOn_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      runD_r <= run;
      out_r <= out_nxt;
      if (!run) begin
        spoOn_r <= 1'b0;
      end else if (mode == `PTC_MODE_SPO && trig && !spoOn_r) begin
        spoOn_r <= 1'b1;
      end else if (spoEnd) begin
        spoOn_r <= 1'b0;
      end
    end
  end

  // Counter zero-extended to the common width
  generate
    if (WIDTH < 16) begin : gExt
      assign cntOut = {{(16-WIDTH){1'b0}}, cnt_r};
    end else begin : gFull
      assign cntOut = cnt_r[15:0];
    end
  endgenerate

  assign lvl = out_r ^ pol;
endmodule // ptc_timer

// File: hw/ptc_top.v
// Periodic timer block: four timers, clock sources, registers, interrupt
//
// Contract
// - Four timers, two 16-bit, two 10-bit
// - Timer, compare, single pulse, PWM modes
// - Counter equal comparator raises interrupt
// - Separate comparator A and P interrupts
// - Three-bit clock select in first control
// - Sources: system, high, sub, external pin
// - External pin clocks the counter
// - External active edge rising or falling
// - External pin triggers single pulse
// - Compare output high, low or toggle
// - Inverted output mirrors primary output
// - Run bit rising edge clears counter
// - Overflow or compare match clears counter
// - Low bytes pass through shared buffer
`include "ptc_defs.vh"
module ptc_top (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire wrEn,
  input wire rdEn,
  output wire [7:0] rdData,
  // Clock source pins
  input wire subClk,
  input wire [15:0] extClkPin,
  // Timer outputs
  output wire [3:0] priOut,
  output wire [3:0] invOut,
  // Interrupt
  output wire irq
);
  integer i;

  reg [7:0] ctl0_r [0:3];
  reg [7:0] ctl1_r [0:3];
  reg [15:0] cmpA_r [0:3];
  reg [15:0] cmpP_r [0:3];
  reg [7:0] lowBuf_r [0:3];
  reg [7:0] route_r;
  reg [7:0] stat_r;
  reg [7:0] mask_r;
  reg [7:0] rdData_r;
  reg [7:0] rdNxt;
  reg [5:0] presc_r;
  reg subQD_r;
  reg [3:0] extQD_r;
  reg [3:0] pri_r;
  reg [3:0] inv_r;

  wire [15:0] cnt [0:3];
  wire [3:0] matchA;
  wire [3:0] matchP;
  wire [3:0] lvl;
  wire [3:0] extQ;
  wire [7:0] statSet;
  wire subQ;

  // ==========================================================
  // Helpers
  // Valid counter and compare bits of a timer
  function [15:0] widthMask;
    input [1:0] idx;
    begin
      widthMask = (idx < 2'h2) ? 16'hFFFF : 16'h03FF;
    end
  endfunction

  // Offset decode of the timer window
  function isTimOfs;
    input [7:0] a;
    input [2:0] ofs;
    begin
      isTimOfs = (a[7:5] == 3'h0) && (a[2:0] == ofs);
    end
  endfunction

  wire timSel = (addr[7:5] == 3'h0);
  wire [1:0] tIdx = addr[4:3];
  wire [2:0] tOfs = addr[2:0];

  // ==========================================================
  // Internal clock dividers, high clock taken as the system clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= 6'h00;
    end else begin
      presc_r <= presc_r + 6'h01;
    end
  end

  wire sys4Tick = (presc_r[1:0] == 2'h3);
  wire h16Tick = (presc_r[3:0] == 4'hF);
  wire h64Tick = (presc_r == 6'h3F);

  // Sub clock pin, rising edge becomes an enable
  ptc_sync uSubSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(subClk),
    .syncOut(subQ)
  );

  wire subTick = subQ & ~subQD_r;

  // Edge history of synchronised pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subQD_r <= 1'b0;
      extQD_r <= 4'h0;
    end else begin
      subQD_r <= subQ;
      extQD_r <= extQ;
    end
  end

  // ==========================================================
  // Timer instances with pin routing and source selection
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gTim
      wire [1:0] pinSel = route_r[7-2*g -: 2];
      wire pinRaw = extClkPin[4*g + pinSel];
      wire rise = extQ[g] & ~extQD_r[g];
      wire fall = ~extQ[g] & extQD_r[g];
      wire actEdge = ctl1_r[g][`PTC_C1_EDGE] ? fall : rise;
      wire [2:0] cks = ctl0_r[g][`PTC_C0_CKS_HI:`PTC_C0_CKS_LO];
      reg tick;

      // Pin synchroniser after the routing multiplexer
      ptc_sync uExtSync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(pinRaw),
        .syncOut(extQ[g])
      );

      // Counter clock enable from the selected source
      always @* begin
        case (cks)
          `PTC_CKS_SYS4: tick = sys4Tick;
          `PTC_CKS_SYS: tick = 1'b1;
          `PTC_CKS_H16: tick = h16Tick;
          `PTC_CKS_H64: tick = h64Tick;
          `PTC_CKS_SUB0: tick = subTick;
          `PTC_CKS_SUB1: tick = subTick;
          default: tick = actEdge;
        endcase
      end

      ptc_timer #(
        .WIDTH((g < 2) ? `PTC_WIDE : `PTC_NARROW)
      ) uTim (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .run(ctl0_r[g][`PTC_C0_RUN]),
        .pause(ctl0_r[g][`PTC_C0_PAU]),
        .mode(ctl1_r[g][`PTC_C1_MODE_HI:`PTC_C1_MODE_LO]),
        .ioSel(ctl1_r[g][`PTC_C1_IO_HI:`PTC_C1_IO_LO]),
        .pol(ctl1_r[g][`PTC_C1_POL]),
        .cclr(ctl1_r[g][`PTC_C1_CCLR]),
        .trig(actEdge),
        .cmpA(cmpA_r[g]),
        .cmpP(cmpP_r[g]),
        .cntOut(cnt[g]),
        .matchA(matchA[g]),
        .matchP(matchP[g]),
        .lvl(lvl[g])
      );

      // Status bit pair: A low, P high
      assign statSet[2*g] = matchA[g];
      assign statSet[2*g+1] = matchP[g];
    end
  endgenerate

  // ==========================================================
  // Output pins, both from flops so they never skew
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_r <= 4'h0;
      inv_r <= 4'hF;
    end else begin
      pri_r <= lvl;
      inv_r <= ~lvl;
    end
  end

  assign priOut = pri_r;
  assign invOut = inv_r;

  // ==========================================================
  // Register writes and buffer transfers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctl0_r[i] <= `PTC_RST_BYTE;
        ctl1_r[i] <= `PTC_RST_BYTE;
        cmpA_r[i] <= 16'h0000;
        cmpP_r[i] <= 16'h0000;
        lowBuf_r[i] <= `PTC_RST_BYTE;
      end
      route_r <= `PTC_RST_BYTE;
      mask_r <= `PTC_RST_BYTE;
    end else begin
      if (wrEn && timSel) begin
        case (tOfs)
          `PTC_OFS_CTL0: ctl0_r[tIdx] <= wrData;
          `PTC_OFS_CTL1: ctl1_r[tIdx] <= wrData;
          `PTC_OFS_CNTL: lowBuf_r[tIdx] <= wrData;
          `PTC_OFS_CMPAL: lowBuf_r[tIdx] <= wrData;
          `PTC_OFS_CMPPL: lowBuf_r[tIdx] <= wrData;
          `PTC_OFS_CMPAH: cmpA_r[tIdx] <= {wrData, lowBuf_r[tIdx]} & widthMask(tIdx);
          `PTC_OFS_CMPPH: cmpP_r[tIdx] <= {wrData, lowBuf_r[tIdx]} & widthMask(tIdx);
          default: ; // Counter high byte is read only
        endcase
      end
      if (rdEn && timSel) begin
        case (tOfs)
          `PTC_OFS_CNTH: lowBuf_r[tIdx] <= cnt[tIdx][7:0];
          `PTC_OFS_CMPAH: lowBuf_r[tIdx] <= cmpA_r[tIdx][7:0];
          `PTC_OFS_CMPPH: lowBuf_r[tIdx] <= cmpP_r[tIdx][7:0];
          default: ;
        endcase
      end
      if (wrEn && addr == `PTC_OFS_ROUTE) begin
        route_r <= wrData;
      end
      if (wrEn && addr == `PTC_OFS_MASK) begin
        mask_r <= wrData;
      end
    end
  end

  // ==========================================================
  // Read multiplexer, low bytes come from the buffer
  always @* begin
    rdNxt = 8'h00;
    if (timSel) begin
      case (tOfs)
        `PTC_OFS_CTL0: rdNxt = ctl0_r[tIdx];
        `PTC_OFS_CTL1: rdNxt = ctl1_r[tIdx];
        `PTC_OFS_CNTH: rdNxt = cnt[tIdx][15:8];
        `PTC_OFS_CMPAH: rdNxt = cmpA_r[tIdx][15:8];
        `PTC_OFS_CMPPH: rdNxt = cmpP_r[tIdx][15:8];
        default: rdNxt = lowBuf_r[tIdx];
      endcase
    end else begin
      case (addr)
        `PTC_OFS_ROUTE: rdNxt = route_r;
        `PTC_OFS_STAT: rdNxt = stat_r;
        `PTC_OFS_MASK: rdNxt = mask_r;
        default: rdNxt = 8'h00;
      endcase
    end
  end

  // Read data held for the cycle after the strobe only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= 8'h00;
    end else if (rdEn) begin
      rdData_r <= rdNxt;
    end else begin
      rdData_r <= 8'h00;
    end
  end

  assign rdData = rdData_r;

  // ==========================================================
  // Sticky status, cleared by reading it; a new match wins
  wire statRd = rdEn && (addr == `PTC_OFS_STAT);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= 8'h00;
    end else begin
      stat_r <= (stat_r & {8{~statRd}}) | statSet;
    end
  end

  assign irq = |(stat_r & mask_r);
endmodule // ptc_top

// File: bench/ptc_checker.sv
// Port-level assertions for the periodic timer block
module ptc_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire wrEn,
  input wire rdEn,
  input wire [7:0] rdData,
  // Pins and interrupt
  input wire subClk,
  input wire [15:0] extClkPin,
  input wire [3:0] priOut,
  input wire [3:0] invOut,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] maskR;
  logic [3:0] runR;
  // ==========
  // Shadow of mask and run bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maskR <= 8'h00;
      runR <= 4'h0;
    end else if (wrEn) begin
      if (addr == 8'h22) maskR <= wrData;
      if (addr[7:5] == 3'h0 && addr[2:0] == 3'h0) runR[addr[4:3]] <= wrData[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Properties
  property p_inv; invOut == ~priOut; endproperty
  property p_rstout; $rose(rst_n) |-> priOut == 4'h0 && invOut == 4'hF; endproperty
  property p_irqmask; irq |-> maskR != 8'h00; endproperty
  property p_irqfall;
    $fell(irq) |-> $past(rdEn && addr == 8'h21) || $past(wrEn && addr == 8'h22);
  endproperty
  property p_maskoff; wrEn && addr == 8'h22 && wrData == 8'h00 |=> !irq; endproperty
  property p_rdidle; !$past(rdEn) |-> rdData == 8'h00; endproperty
  property p_narrow;
    rdEn && addr[7:4] == 4'h1 && addr[0] && addr[2:1] != 2'h0 |=> rdData[7:2] == 6'h00;
  endproperty
  property p_runclr;
    wrEn && addr == 8'h00 && wrData[7] && !runR[0] ##2 rdEn && addr == 8'h03
      |=> rdData == 8'h00;
  endproperty
  a_inv: assert property (p_inv)
    else $error("inverted output not inverse");
  a_rstout: assert property (p_rstout)
    else $error("outputs wrong after reset");
  a_irqmask: assert property (p_irqmask)
    else $error("interrupt with all masked");
  a_irqfall: assert property (p_irqfall)
    else $error("interrupt dropped without clear");
  a_maskoff: assert property (p_maskoff)
    else $error("interrupt after mask cleared");
  a_rdidle: assert property (p_rdidle)
    else $error("read data without read");
  a_narrow: assert property (p_narrow)
    else $error("narrow timer high bits set");
  a_runclr: assert property (p_runclr)
    else $error("counter not cleared by run");
  c_irq: cover property ($rose(irq));
  c_out: cover property ($changed(priOut));
  c_run: cover property (runR[0] ##1 !runR[0]);
endmodule // ptc_checker

bind ptc_top ptc_checker ptc_checker_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .subClk(subClk),
  .extClkPin(extClkPin), .priOut(priOut), .invOut(invOut), .irq(irq));

// File: bench/ptc_pin_model.sv
// External clock pins and sub clock feeding the periodic timer block
module ptc_pin_model (
  // Clock
  input wire clk,
  // Pins toward the timers
  output logic subClk,
  output logic [15:0] extClkPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] noise = 16'hA5A5;
  logic [15:0] own = 16'h0000;
  logic [15:0] used = 16'h0000;
  initial subClk = 1'h0;
  // Free running sub clock, period of 31 clk cycles, edges on clk edges
  always #310 subClk = ~subClk;
  // Idle pins never hold still
  always @(posedge clk) noise <= ~noise;
  assign extClkPin = (used & own) | (~used & noise);
  // Toggle one pin n times, four clocks per level
  task burst(input int p, input int n);
    used[p] = 1'h1;
    repeat (n) begin
      @(posedge clk);
      own[p] <= ~own[p];
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // ptc_pin_model

// File: bench/ptc_tb_top.sv
// Self-checking testbench of the periodic timer block
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin badCount++; \
  $display("unexpected %0t: got %h want %h", $time, a, e); end end
module ptc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'h0;
  logic rdEn = 1'h0;
  wire [7:0] rdData;
  wire subClk;
  wire [15:0] extClkPin;
  wire [3:0] priOut;
  wire [3:0] invOut;
  wire irq;
  int badCount = 0;
  int checksDone = 0;
  int cyc = 0;
  int i;
  int n;
  logic [7:0] h;
  logic [15:0] v;
  logic b;
  // Rows: high byte address, written value, readback
  localparam logic [39:0] PAIRS [4] = '{40'h05_1234_1234, 40'h0F_ABCD_ABCD,
    40'h15_FFFF_03FF, 40'h1F_5A5A_025A};
  // Rows: clock select code, ticks in the run window
  int srcTab[6] = '{1, 0, 2, 3, 4, 5};
  int expTab[6] = '{244, 61, 15, 4, 8, 8};
  always #10 clk = ~clk;
  ptc_top ptc_top_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .subClk(subClk), .extClkPin(extClkPin),
    .priOut(priOut), .invOut(invOut), .irq(irq));
  ptc_pin_model ptc_pin_model_inst (.clk(clk), .subClk(subClk), .extClkPin(extClkPin));
  // ==========
  // Bus tasks and closing
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'h1;
    @(posedge clk);
    wrEn <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'h1;
    @(posedge clk);
    rdEn <= 1'h0;
    #1 d = rdData;
  endtask
  task rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(a, hi);
    rd(a - 8'h01, lo);
    d = {hi, lo};
  endtask
  task finalReport;
    $display("checks %0d, mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      badCount++;
      $display("unexpected %0t: timeout", $time);
      finalReport;
    end
  end
  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    #1 `CHK({priOut, invOut, irq}, 9'h01E)
    rd(8'h20, h);
    `CHK(h, 8'h00)
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      wr(PAIRS[i][39:32] - 8'h01, PAIRS[i][23:16]);
      wr(PAIRS[i][39:32], PAIRS[i][31:24]);
      rd16(PAIRS[i][39:32], v);
      `CHK(v, PAIRS[i][15:0])
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, h);
    `CHK(h, 8'h00)
    $display("register test done");
    wr(8'h05, 8'hFF);
    wr(8'h07, 8'hFF);
    wr(8'h01, 8'h40);
    for (i = 0; i < 6; i++) begin
      wr(8'h00, 8'h80 | 8'(srcTab[i]));
      rd(8'h03, h);
      `CHK(h, 8'h00)
      repeat (240) @(posedge clk);
      wr(8'h00, 8'(srcTab[i]));
      rd16(8'h03, v);
      `CHK(v >= expTab[i] - 2 && v <= expTab[i] + 2, 1'h1)
    end
    // Paused counter must stay at zero after the run edge
    wr(8'h00, 8'hC1);
    repeat (20) @(posedge clk);
    rd16(8'h03, v);
    `CHK(v, 16'h0000)
    wr(8'h00, 8'h01);
    $display("clock source test done");
    ptc_pin_model_inst.burst(2, 0);
    wr(8'h20, 8'h80);
    rd(8'h20, h);
    `CHK(h, 8'h80)
    for (i = 0; i < 2; i++) begin
      wr(8'h01, 8'h40 | 8'(i * 4));
      wr(8'h00, 8'h86);
      ptc_pin_model_inst.burst(2, 6 - i);
      repeat (8) @(posedge clk);
      wr(8'h00, 8'h06);
      rd16(8'h03, v);
      `CHK(v, 16'(3 - i))
    end
    $display("external pin test done");
    wr(8'h04, 8'h14);
    wr(8'h05, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'hC0);
    wr(8'h00, 8'h81);
    repeat (10) @(posedge clk);
    #1 `CHK(priOut[0], 1'h0)
    ptc_pin_model_inst.burst(2, 2);
    repeat (6) @(posedge clk);
    #1 `CHK(priOut[0], 1'h1)
    repeat (30) @(posedge clk);
    #1 `CHK(priOut[0], 1'h0)
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h02);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h07);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h80);
    wr(8'h00, 8'h81);
    repeat (20) @(posedge clk);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      #1 n += (priOut[0] === 1'h1);
    end
    `CHK(n, 16)
    $display("pulse and duty test done");
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h03);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h30);
    wr(8'h00, 8'h81);
    repeat (20) @(posedge clk);
    #1 b = priOut[0];
    repeat (2) begin
      repeat (4) @(posedge clk);
      #1 b = ~b;
      `CHK(priOut[0], b)
      `CHK(invOut[0], ~b)
    end
    // Clear on match A: period of two, toggle every second cycle
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h31);
    wr(8'h00, 8'h81);
    repeat (10) @(posedge clk);
    #1 b = priOut[0];
    repeat (2) begin
      repeat (2) @(posedge clk);
      #1 b = ~b;
      `CHK(priOut[0], b)
    end
    for (i = 0; i < 2; i++) begin
      wr(8'h01, i ? 8'h10 : 8'h20);
      repeat (10) @(posedge clk);
      #1 `CHK(priOut[0], 1'(1 - i))
    end
    // Polarity flips the pin pair while the output is held low
    wr(8'h01, 8'h18);
    repeat (4) @(posedge clk);
    #1 `CHK({priOut[0], invOut[0]}, 2'h2)
    rd(8'h21, h);
    wr(8'h22, 8'h03);
    repeat (2) @(posedge clk);
    #1 `CHK(irq, 1'h1)
    wr(8'h00, 8'h01);
    repeat (6) @(posedge clk);
    #1 `CHK(irq, 1'h1)
    rd(8'h21, h);
    `CHK(h, 8'h03)
    `CHK(irq, 1'h0)
    rd(8'h21, h);
    `CHK(h, 8'h00)
    wr(8'h22, 8'h00);
    $display("compare and interrupt test done");
    finalReport;
  end
endmodule // ptc_tb_top
